// ### pkg/nrs_pkg.sv
// Constants, field layout and state type for the node register set.
// Assumes a single 50 MHz clock and 32-bit register words.
package nrs_pkg;

    // ---------------------------------------------------------------
    // Register offsets from the nodespace base
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_DEVICE_IDENTITY = 8'h00;
    localparam logic [7:0] OFS_BUS_ERROR_STATUS = 8'h04;
    localparam logic [7:0] OFS_FAILING_ADDRESS = 8'h08;
    localparam logic [7:0] OFS_GENERAL_PURPOSE = 8'h0C;
    localparam logic [7:0] OFS_NODE_SPECIFIC = 8'h1C;
    localparam logic [7:0] OFS_BUS_CONTROL = 8'h24;
    localparam logic [7:0] OFS_FAILING_ADDR_EXT = 8'h2C;
    localparam logic [7:0] OFS_BUS_ERROR_EXT = 8'h34;

    // Nodespace window: upper bits compared against the base
    localparam int NODESPACE_W = 19;
    localparam int OFS_W = 8;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int REV_MSB = 31;
    localparam int REV_LSB = 16;
    localparam int TYPE_MSB = 15;
    localparam int TYPE_LSB = 0;
    localparam int BIT_ERROR_SUMMARY = 31;
    localparam int BIT_NODE_RESET = 30;
    localparam int BIT_NODE_HALT = 29;
    localparam int BIT_FAULT_LINE = 28;
    localparam int CMDR_ID_MSB = 3;
    localparam int CMDR_ID_LSB = 0;

    // Error bits folded into the summary (27,25..15,13)
    localparam logic [31:0] ERR_FLAG_MASK = 32'h0BFF_A000;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [3:0] RST_CMDR_ID = 4'h0;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int INIT_TIME_NS = 1000;
    localparam int INIT_CYCLES =
        (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] INIT_CYCLES_W8 = 8'(INIT_CYCLES);

    // Reset/self-test sequencer states
    typedef enum logic [1:0] {
        ST_INIT = 2'b00,
        ST_TEST = 2'b01,
        ST_FAIL = 2'b10,
        ST_RUN = 2'b11
    } nrs_seq_t;

endpackage

// ### src/nrs_init_seq.sv
// Initialization and self-test sequencer for one node.
// Assumes the node core reports self-test completion and its outcome.
`timescale 1ns/1ns

module nrs_init_seq (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic holdInit,
    input wire logic startReset,
    input wire logic testDone,
    input wire logic testOk,
    output logic nodeInit_r,
    output logic initEnd_r,
    output logic busy_r
);

    nrs_pkg::nrs_seq_t state_r;
    logic [7:0] count_r;

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    // Power-up and node reset share one path, so both run self-test
    always_ff @(posedge ref_clk) begin
        if (!reset_n || holdInit) begin
            state_r <= nrs_pkg::ST_INIT;
            count_r <= 8'h00;
        end else if (startReset) begin
            state_r <= nrs_pkg::ST_INIT;
            count_r <= 8'h00;
        end else begin
            unique case (state_r)
                nrs_pkg::ST_INIT: begin
                    if (count_r == nrs_pkg::INIT_CYCLES_W8 - 8'h01) begin
                        state_r <= nrs_pkg::ST_TEST;
                    end
                    count_r <= count_r + 8'h01;
                end
                nrs_pkg::ST_TEST: begin
                    if (testDone) begin
                        state_r <= testOk ? nrs_pkg::ST_RUN
                                          : nrs_pkg::ST_FAIL;
                    end
                end
                // Failed test keeps the fault line up until a reset or power-fail restarts init
                nrs_pkg::ST_FAIL: state_r <= nrs_pkg::ST_FAIL;
                nrs_pkg::ST_RUN: state_r <= nrs_pkg::ST_RUN;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Registered status outputs
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            nodeInit_r <= 1'b1;
            initEnd_r <= 1'b0;
            busy_r <= 1'b1;
        end else begin
            nodeInit_r <= holdInit || startReset ||
                (state_r == nrs_pkg::ST_INIT &&
                 count_r != nrs_pkg::INIT_CYCLES_W8 - 8'h01);
            initEnd_r <= !holdInit && !startReset &&
                state_r == nrs_pkg::ST_INIT &&
                count_r == nrs_pkg::INIT_CYCLES_W8 - 8'h01;
            busy_r <= holdInit || startReset ||
                !(state_r == nrs_pkg::ST_RUN ||
                  (state_r == nrs_pkg::ST_TEST && testDone && testOk));
        end
    end

endmodule

// ### src/nrs_node_regs.sv
// Required per-node register set of a system-bus node.
// Assumes bus transactions arrive already decoded to address and
// read/write strobes on ref_clk, and that power-fail is synchronous.
//
// Contract
// - Registers sit at fixed byte offsets from the nodespace base.
// - Identity, bus error and extension always; commander set too.
// - Offsets are taken from the first nodespace address.
// - Write-one-to-clear bits read their state; a 0 write keeps them.
// - Identity resets to zero and is loaded during initialization.
// - Identity bits 31..16 hold a read/write revision value.
// - Identity bits 15..0 hold a read/write class and identifier.
// - A failed transaction captures error bit and commander id.
// - Captured error status stays frozen until software clears it.
// - Bit 31 reads as the OR of the listed error bits.
// - Writing 1 to bit 30 starts a full power-up style reset.
// - Node reset runs self-test, fault line held until it passes.
// - A resetting node issues no accesses on the system bus.
// - Power-fail clears the reset bit; a node reset leaves it set.
// - Writing 1 to bit 29 puts the node in a quiet state; here it only raises haltRequest_r and the commander path stays open.
// - With halt set the processor stops and awaits the console.
// - Bit 28 reads the fault line; writes drive or release it.
// - Bit 27 is a sticky corrected confirmation error flag.
`timescale 1ns/1ns

module nrs_node_regs (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic powerFail_n,
    input wire logic [31:0] nodespaceBase,
    input wire logic [31:0] busAddr,
    input wire logic busRead,
    input wire logic busWrite,
    input wire logic [31:0] busWrData,
    output logic [31:0] rdData_r,
    output logic rdValid_r,
    output logic busAck_r,
    output logic busRefused_r,
    input wire logic errStrobe,
    input wire logic [31:0] errFlags,
    input wire logic [3:0] errCommanderId,
    input wire logic [31:0] errAddr,
    input wire logic [31:0] errAddrExt,
    input wire logic [15:0] initRevision,
    input wire logic [15:0] initNodeType,
    input wire logic testDone,
    input wire logic testOk,
    output logic nodeInit_r,
    output logic commanderEnable_r,
    output logic haltRequest_r,
    input wire logic faultLineIn_n,
    output logic faultLineOut_n_r,
    output logic faultLineOe_r
);

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    logic inNodespace;
    logic [nrs_pkg::OFS_W-1:0] offset;
    logic busReq;
    logic accepted;
    logic wrAcc;
    logic rdAcc;
    logic seqBusy;


    // Upper address bits must match the base; offset is the remainder
    assign inNodespace =
        busAddr[31:nrs_pkg::NODESPACE_W] ==
        nodespaceBase[31:nrs_pkg::NODESPACE_W];
    assign offset = busAddr[nrs_pkg::OFS_W-1:0];
    assign busReq = inNodespace && (busRead || busWrite);

    // No register access while initializing or testing
    assign accepted = busReq && !seqBusy;
    assign wrAcc = accepted && busWrite;
    // A write wins over a read
    assign rdAcc = accepted && busRead && !busWrite;

    // Only offsets inside the register page decode to registers
    logic inPage;

    assign inPage =
        busAddr[nrs_pkg::NODESPACE_W-1:nrs_pkg::OFS_W] == '0;

    logic wrIdentity;
    logic wrBusError;
    logic wrGeneral;
    assign wrIdentity = wrAcc && inPage &&
        offset == nrs_pkg::OFS_DEVICE_IDENTITY;
    assign wrBusError = wrAcc && inPage &&
        offset == nrs_pkg::OFS_BUS_ERROR_STATUS;
    assign wrGeneral = wrAcc && inPage &&
        offset == nrs_pkg::OFS_GENERAL_PURPOSE;

    // ---------------------------------------------------------------
    // Reset and self-test sequencing
    // ---------------------------------------------------------------
    logic seqInit;
    logic seqInitEnd;
    logic nodeResetStart;
    logic powerFail;

    assign powerFail = !powerFail_n;

    // A node reset request is a write of 1 to bit 30
    assign nodeResetStart =
        wrBusError && busWrData[nrs_pkg::BIT_NODE_RESET];

    // Power-fail holds it in init
    nrs_init_seq u_init_seq (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .holdInit(powerFail),
        .startReset(nodeResetStart),
        .testDone(testDone),
        .testOk(testOk),
        .nodeInit_r(seqInit),
        .initEnd_r(seqInitEnd),
        .busy_r(seqBusy)
    );

    // Local reset covers both power-up and software node reset
    logic localReset;
    assign localReset = !reset_n || powerFail || nodeResetStart;

    // ---------------------------------------------------------------
    // Device identity
    // ---------------------------------------------------------------
    logic [15:0] revision_r;
    logic [15:0] nodeType_r;

    // Zero until loaded, so a zero read marks an unready node
    always_ff @(posedge ref_clk) begin
        if (localReset) begin
            revision_r <= nrs_pkg::RST_WORD[15:0];
            nodeType_r <= nrs_pkg::RST_WORD[15:0];
        end else if (seqInitEnd) begin
            revision_r <= initRevision;
            nodeType_r <= initNodeType;
        end else if (wrIdentity) begin
            revision_r <=
                busWrData[nrs_pkg::REV_MSB:nrs_pkg::REV_LSB];
            nodeType_r <=
                busWrData[nrs_pkg::TYPE_MSB:nrs_pkg::TYPE_LSB];
        end
    end

    // ---------------------------------------------------------------
    // Bus error flags and captured status
    // ---------------------------------------------------------------
    logic [31:0] errHeld_r;
    logic [3:0] cmdrId_r;
    logic [31:0] failAddr_r;
    logic [31:0] failAddrExt_r;

    logic [31:0] clearMask;
    logic [31:0] afterClear;
    logic [31:0] newErr;
    logic locked;
    logic capture;

    // Only listed error bits are writable-to-clear; others ignore 1s
    assign clearMask = wrBusError ?
        (busWrData & nrs_pkg::ERR_FLAG_MASK) : '0;
    assign afterClear = errHeld_r & ~clearMask;
    assign newErr = errFlags & nrs_pkg::ERR_FLAG_MASK;

    // Status stays locked while any flag survives this cycle's clear
    assign locked = |afterClear;
    // A fresh error in the clearing cycle is still taken
    assign capture = errStrobe && |newErr && !locked;

    // Flag state
    always_ff @(posedge ref_clk) begin
        if (localReset) begin
            errHeld_r <= nrs_pkg::RST_WORD;
        end else if (capture) begin
            errHeld_r <= afterClear | newErr;
        end else begin
            errHeld_r <= afterClear;
        end
    end

    // Commander identity and failing address, frozen with the flags
    always_ff @(posedge ref_clk) begin
        if (localReset) begin
            cmdrId_r <= nrs_pkg::RST_CMDR_ID;
            failAddr_r <= nrs_pkg::RST_WORD;
            failAddrExt_r <= nrs_pkg::RST_WORD;
        end else if (capture) begin
            cmdrId_r <= errCommanderId;
            failAddr_r <= errAddr;
            failAddrExt_r <= errAddrExt;
        end
    end

    // Summary is pure combinational OR; nothing stores it
    logic errorSummary;

    assign errorSummary = |(errHeld_r & nrs_pkg::ERR_FLAG_MASK);

    // ---------------------------------------------------------------
    // Node reset, halt and fault line control bits
    // ---------------------------------------------------------------
    logic nodeResetBit_r;
    logic nodeHaltBit_r;
    logic faultDrive_r;

    // Only power-up reset or power-fail clears the reset bit; node reset keeps it set
    always_ff @(posedge ref_clk) begin
        if (!reset_n || powerFail) begin
            nodeResetBit_r <= 1'b0;
        end else if (wrBusError) begin
            nodeResetBit_r <=
                nodeResetBit_r | busWrData[nrs_pkg::BIT_NODE_RESET];
        end
    end

    // Halt bit survives until written 0 or the node is reset
    always_ff @(posedge ref_clk) begin
        if (localReset) begin
            nodeHaltBit_r <= 1'b0;
        end else if (wrBusError) begin
            nodeHaltBit_r <= busWrData[nrs_pkg::BIT_NODE_HALT];
        end
    end

    // Software part of the fault line drive
    always_ff @(posedge ref_clk) begin
        if (localReset) begin
            faultDrive_r <= 1'b0;
        end else if (wrBusError) begin
            faultDrive_r <= busWrData[nrs_pkg::BIT_FAULT_LINE];
        end
    end

    // General purpose scratch word for the commander
    logic [31:0] generalPurpose_r;

    always_ff @(posedge ref_clk) begin
        if (localReset) begin
            generalPurpose_r <= nrs_pkg::RST_WORD;
        end else if (wrGeneral) begin
            generalPurpose_r <= busWrData;
        end
    end

    // ---------------------------------------------------------------
    // Read data
    // ---------------------------------------------------------------
    logic [31:0] rdMux;
    logic [31:0] busErrorWord;

    // Fault bit shows the line level, not just our own drive
    always_comb begin
        busErrorWord = errHeld_r & nrs_pkg::ERR_FLAG_MASK;
        busErrorWord[nrs_pkg::BIT_ERROR_SUMMARY] = errorSummary;
        busErrorWord[nrs_pkg::BIT_NODE_RESET] = nodeResetBit_r;
        busErrorWord[nrs_pkg::BIT_NODE_HALT] = nodeHaltBit_r;
        busErrorWord[nrs_pkg::BIT_FAULT_LINE] = !faultLineIn_n;
        busErrorWord[nrs_pkg::CMDR_ID_MSB:nrs_pkg::CMDR_ID_LSB] =
            cmdrId_r;
    end

    // Optional and layout-less registers read as zero
    always_comb begin
        rdMux = '0;
        if (inPage) begin
            unique case (offset)
                nrs_pkg::OFS_DEVICE_IDENTITY:
                    rdMux = {revision_r, nodeType_r};
                nrs_pkg::OFS_BUS_ERROR_STATUS:
                    rdMux = busErrorWord;
                nrs_pkg::OFS_FAILING_ADDRESS:
                    rdMux = failAddr_r;
                nrs_pkg::OFS_GENERAL_PURPOSE:
                    rdMux = generalPurpose_r;
                nrs_pkg::OFS_FAILING_ADDR_EXT:
                    rdMux = failAddrExt_r;
                nrs_pkg::OFS_NODE_SPECIFIC,
                nrs_pkg::OFS_BUS_CONTROL,
                nrs_pkg::OFS_BUS_ERROR_EXT:
                    rdMux = '0;
                default:
                    rdMux = '0;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Bus answer
    // ---------------------------------------------------------------
    // One-cycle answer; data stays until the next read
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rdData_r <= nrs_pkg::RST_WORD;
            rdValid_r <= 1'b0;
            busAck_r <= 1'b0;
            busRefused_r <= 1'b0;
        end else begin
            if (rdAcc) begin
                rdData_r <= rdMux;
            end
            rdValid_r <= rdAcc;
            busAck_r <= accepted;
            // Refusal has no effect
            busRefused_r <= busReq && seqBusy;
        end
    end

    // ---------------------------------------------------------------
    // Outputs to the node core and the fault line
    // ---------------------------------------------------------------
    // Commander path stays shut while resetting, testing or in power-fail; halt leaves it open
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            nodeInit_r <= 1'b1;
            commanderEnable_r <= 1'b0;
            haltRequest_r <= 1'b0;
        end else begin
            nodeInit_r <= seqInit || nodeResetStart;
            commanderEnable_r <= !seqBusy && !nodeResetStart &&
                !powerFail;
            haltRequest_r <= nodeHaltBit_r;
        end
    end

    // Open-drain: pull low while testing or when software asks
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            faultLineOut_n_r <= 1'b0;
            faultLineOe_r <= 1'b1;
        end else begin
            faultLineOut_n_r <= 1'b0;
            faultLineOe_r <= seqBusy || nodeResetStart ||
                faultDrive_r;
        end
    end

endmodule

// ### testbench/nrs_node_regs_chk.sv
// Port checker for the node register set.
// Assumes it is bound onto every nrs_node_regs instance.
`timescale 1ns/1ns

module nrs_regs_chk (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic powerFail_n,
    input wire logic [31:0] nodespaceBase,
    input wire logic [31:0] busAddr,
    input wire logic busRead,
    input wire logic busWrite,
    input wire logic [31:0] busWrData,
    input wire logic [31:0] rdData_r,
    input wire logic rdValid_r,
    input wire logic busAck_r,
    input wire logic busRefused_r,
    input wire logic nodeInit_r,
    input wire logic commanderEnable_r,
    input wire logic haltRequest_r,
    input wire logic faultLineOut_n_r,
    input wire logic faultLineOe_r
);
    logic req;
    logic berWr;

    // Request decode, seen exactly as the node sees it
    assign req = busAddr[31:19] == nodespaceBase[31:19] &&
        (busRead || busWrite);
    assign berWr = req && busWrite && busAddr[18:0] == 19'h00004;

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    // Power-fail acts as a reset, so both silence all checks but a_reset_state
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n || !powerFail_n);

    a_ack_has_cause: assert property (
        busAck_r |-> $past(req))
        else $error("ack without a request");
    a_read_valid: assert property (
        rdValid_r |-> busAck_r && $past(busRead && !busWrite))
        else $error("read valid without read ack");
    a_refuse_clean: assert property (
        busRefused_r |-> $past(req) && !busAck_r && !rdValid_r)
        else $error("refusal malformed");
    a_busy_quiet: assert property (
        nodeInit_r |-> !commanderEnable_r)
        else $error("bus access enabled during init");
    a_init_fault: assert property (
        nodeInit_r |-> faultLineOe_r)
        else $error("fault line free during init");
    a_drain_low: assert property (
        faultLineOut_n_r == 1'b0)
        else $error("fault line driven high");
    a_summary_or: assert property (
        rdValid_r && $past(busAddr[18:0] == 19'h00004) |->
            rdData_r[31] == |(rdData_r & nrs_pkg::ERR_FLAG_MASK))
        else $error("summary bit disagrees with flags");
    a_halt_write: assert property (
        busAck_r && $past(berWr && !busWrData[30]) |=>
            haltRequest_r == $past(busWrData[29], 2))
        else $error("halt bit not written");
    a_node_reset: assert property (
        busAck_r && $past(berWr && busWrData[30]) |->
            ##[0:2] (nodeInit_r && !commanderEnable_r))
        else $error("node reset did not restart init");
    a_reset_state: assert property (disable iff (1'b0)
        !reset_n |=> nodeInit_r && faultLineOe_r && !haltRequest_r)
        else $error("reset state wrong");

    c_refused: cover property (busRefused_r);
    c_error_read: cover property (rdValid_r && rdData_r[31]);
    c_init_end: cover property ($fell(nodeInit_r));
endmodule

bind nrs_node_regs nrs_regs_chk u_chk (.ref_clk, .reset_n, .powerFail_n,
    .nodespaceBase, .busAddr, .busRead, .busWrite, .busWrData,
    .rdData_r, .rdValid_r, .busAck_r, .busRefused_r, .nodeInit_r,
    .commanderEnable_r, .haltRequest_r, .faultLineOut_n_r,
    .faultLineOe_r);

// ### testbench/nrs_peer_model.sv
// Model of the node core self-test and of the other nodes on the
// pulled-up wired-OR fault line.
`timescale 1ns/1ns

module nrs_peer_model #(
    parameter int TEST_CYC = 20
) (
    input wire logic ref_clk,
    input wire logic nodeInit_r,
    input wire logic passTest,
    input wire logic peerBad,
    input wire logic faultOe,
    input wire logic faultOut_n,
    output logic testDone,
    output logic testOk,
    output logic faultLine_n
);
    logic [7:0] cnt_r;

    // Self-test time counts from end of init; saturates so it reports once
    always_ff @(posedge ref_clk) begin
        if (nodeInit_r) begin
            cnt_r <= 8'h00;
        end else if (cnt_r != 8'hFF) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

    // One-cycle report; outcome chosen by the bench
    assign testDone = cnt_r == 8'(TEST_CYC);
    assign testOk = testDone && passTest;
    // Pull-up wins only when nobody pulls the line low
    assign faultLine_n = !((faultOe && !faultOut_n) || peerBad);
endmodule

// ### testbench/tb.sv
// Self-checking bench for the node register set.
// Assumes the peer model and the checker are compiled before it.
`timescale 1ns/1ns

module tb;
    localparam logic [31:0] BASE = 32'h2008_0000;
    localparam logic [31:0] ID0 = 32'h1234_0102;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic powerFail_n = 1'b1;
    logic busRead = 1'b0;
    logic busWrite = 1'b0;
    logic [31:0] busAddr = 32'h0;
    logic [31:0] busWrData = 32'h0;
    logic errStrobe = 1'b0;
    logic [31:0] errFlags = 32'h0;
    logic [3:0] errCommanderId = 4'h0;
    logic [31:0] errAddr = 32'h0;
    logic passTest = 1'b1;
    logic peerBad = 1'b0;
    logic [31:0] rdData_r, q, ex;
    logic rdValid_r, busAck_r, busRefused_r, nodeInit_r, testDone;
    logic commanderEnable_r, haltRequest_r, faultLineOut_n_r, testOk;
    logic faultLineOe_r, faultLine_n, ack, refd;
    int fails = 0;
    int cmp_count = 0;

    always #10 ref_clk = ~ref_clk;

    nrs_node_regs DUT (.ref_clk, .reset_n, .powerFail_n,
        .nodespaceBase(BASE), .busAddr, .busRead, .busWrite, .busWrData,
        .rdData_r, .rdValid_r, .busAck_r, .busRefused_r, .errStrobe,
        .errFlags, .errCommanderId, .errAddr, .errAddrExt(~errAddr),
        .initRevision(ID0[31:16]), .initNodeType(ID0[15:0]), .testDone,
        .testOk, .nodeInit_r, .commanderEnable_r, .haltRequest_r,
        .faultLineIn_n(faultLine_n), .faultLineOut_n_r, .faultLineOe_r);
    nrs_peer_model u_peer (.ref_clk, .nodeInit_r, .passTest, .peerBad,
        .faultOe(faultLineOe_r), .faultOut_n(faultLineOut_n_r),
        .testDone, .testOk, .faultLine_n);

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic complete_run();
        $display("Counts: %0d compared, %0d bad", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", what, e, g);
        end
    endtask

    task automatic chkb(input string what, input logic e, g);
        chk(what, {31'h0, e}, {31'h0, g});
    endtask

    // One access; request held over the taking edge, answer seen after
    task automatic acc(input logic wr, input logic [31:0] ofs, d);
        @(negedge ref_clk);
        busWrite = wr;
        busRead = !wr;
        busAddr = BASE + ofs;
        busWrData = d;
        @(negedge ref_clk);
        q = rdData_r;
        ack = busAck_r;
        refd = busRefused_r;
        busWrite = 1'b0;
        busRead = 1'b0;
    endtask

    // Mask m hides bits a clear may leave
    task automatic rdm(input logic [31:0] ofs, e, m, input string what);
        acc(1'b0, ofs, 32'h0);
        chkb("ack", 1'b1, ack);
        chk(what, e & m, q & m);
    endtask

    task automatic err(input logic [31:0] f, input logic [3:0] id);
        @(negedge ref_clk);
        errStrobe = 1'b1;
        errFlags = f;
        errCommanderId = id;
        errAddr = ~f;
        @(negedge ref_clk);
        errStrobe = 1'b0;
    endtask

    // Bounded wait for the end of init and self-test
    task automatic wait_up();
        int n;
        n = 0;
        while (commanderEnable_r !== 1'b1 && n < 500) begin
            @(negedge ref_clk);
            n++;
        end
        chkb("ready", 1'b1, commanderEnable_r);
    endtask

    task automatic pf_pulse();
        @(negedge ref_clk);
        powerFail_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        powerFail_n = 1'b1;
    endtask

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(negedge ref_clk);
        reset_n = 1'b1;
        acc(1'b0, 32'h0, 32'h0);
        chkb("refused", 1'b1, refd);
        chkb("init fault", 1'b1, faultLineOe_r);
        wait_up();
        $display("test init done");
        rdm(32'h0, ID0, '1, "identity");
        acc(1'b1, 32'h0, 32'hA5A5_5A5A);
        rdm(32'h0, 32'hA5A5_5A5A, '1, "identity rw");
        acc(1'b1, 32'hC, 32'hCAFE_0001);
        rdm(32'hC, 32'hCAFE_0001, '1, "general");
        rdm(32'h1C, 32'h0, '1, "nscs");
        rdm(32'h24, 32'h0, '1, "control");
        rdm(32'h34, 32'h0, '1, "ext");
        rdm(32'h40, 32'h0, '1, "unmapped");
        acc(1'b0, 32'h0008_0000, 32'h0);
        chkb("foreign", 1'b0, ack);
        $display("test map done");
        // Each flag: capture, lock, 0-write, summary write, then clear
        for (int i = 13; i < 28; i++) begin
            if (nrs_pkg::ERR_FLAG_MASK[i]) begin
                ex = 32'h8000_0000 | (32'h1 << i) | 32'(i[3:0]);
                err(32'h1 << i, i[3:0]);
                err(32'h0800_2000 & ~(32'h1 << i), 4'hF);
                rdm(32'h4, ex, '1, "capture");
                rdm(32'h8, ~(32'h1 << i), '1, "fail addr");
                rdm(32'h2C, 32'h1 << i, '1, "fail ext");
                acc(1'b1, 32'h4, 32'h8000_0000);
                rdm(32'h4, ex, '1, "w0 keeps");
                acc(1'b1, 32'h4, 32'h1 << i);
                rdm(32'h4, 32'h0, 32'hFFFF_FFF0, "cleared");
            end
        end
        $display("test errors done");
        acc(1'b1, 32'h4, 32'h3000_0000);
        @(negedge ref_clk);
        chkb("halt", 1'b1, haltRequest_r);
        chkb("drive", 1'b1, faultLineOe_r);
        rdm(32'h4, 32'h3000_0000, 32'hFFFF_FFF0, "halt fault");
        peerBad = 1'b1;
        acc(1'b1, 32'h4, 32'h0);
        @(negedge ref_clk);
        chkb("unhalt", 1'b0, haltRequest_r);
        rdm(32'h4, 32'h1000_0000, 32'hFFFF_FFF0, "peer pull");
        peerBad = 1'b0;
        rdm(32'h4, 32'h0, 32'hFFFF_FFF0, "released");
        $display("test control done");
        acc(1'b1, 32'h4, 32'h4000_0000);
        @(negedge ref_clk);
        chkb("quiet", 1'b0, commanderEnable_r);
        chkb("reset fault", 1'b1, faultLineOe_r);
        acc(1'b0, 32'h0, 32'h0);
        chkb("reset busy", 1'b1, refd);
        wait_up();
        rdm(32'h4, 32'h4000_0000, 32'hFFFF_FFF0, "node_reset_bit kept");
        rdm(32'h0, ID0, '1, "reloaded");
        rdm(32'hC, 32'h0, '1, "gp cleared");
        $display("test node reset done");
        passTest = 1'b0;
        pf_pulse();
        // Init plus self-test take 70 cycles; 120 leaves margin
        repeat (120) @(negedge ref_clk);
        acc(1'b0, 32'h0, 32'h0);
        chkb("failed busy", 1'b1, refd);
        chkb("failed fault", 1'b1, faultLineOe_r);
        passTest = 1'b1;
        pf_pulse();
        wait_up();
        rdm(32'h4, 32'h0, 32'hFFFF_FFF0, "power clears");
        $display("test power done");
        complete_run();
    end

    // Whole run needs under 1000 cycles; 5000 means a hang
    initial begin
        #100000;
        fails++;
        complete_run();
    end
endmodule
